/* dv/bps_analog_model.sv */
`timescale 1ns/1ps
module bps_analog_model (
    // clock
    input  wire  aclk,
    // gate and discharge commands from the sequencer, trip enable from the testbench
    input  wire  hs_gate,
    input  wire  ss_discharge,
    input  wire  trip_en,
    // oscillator and comparator levels
    output logic cycle_start,
    output logic peak_current_trip,
    output logic ss_above_1v4,
    output logic ss_at_ground,
    output logic ss_below_ref
);
    logic [5:0] ss_lvl_q = 6'h00;
    logic       osc_q    = 1'b0;
    logic       peak_q   = 1'b0;
    // a tick every second clock keeps both 16384-tick hiccups inside the run budget
    always @(posedge aclk) begin
        osc_q <= ~osc_q;
        peak_q <= hs_gate & trip_en;
        if (ss_discharge) ss_lvl_q <= 6'h00;
        else if (ss_lvl_q != 6'h3F) ss_lvl_q <= ss_lvl_q + 6'h01;
    end
    assign cycle_start = osc_q;
    assign peak_current_trip = peak_q;
    // node ramps after discharge and crosses the reference before the 1.4V level
    assign ss_at_ground = (ss_lvl_q == 6'h00);
    assign ss_below_ref = (ss_lvl_q < 6'h18);
    assign ss_above_1v4 = (ss_lvl_q > 6'h20);
endmodule // bps_analog_model

/* dv/bps_seq_props.sv */
`timescale 1ns/1ps
module bps_seq_props (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // comparator flags
    input wire undervoltage_lockout,
    input wire enable_above_thresh,
    input wire thermal_hot,
    input wire fb_in_window,
    input wire fb_out_window,
    input wire overvoltage_guard,
    input wire boot_uv,
    input wire ls_source_limit,
    input wire ss_above_1v4,
    input wire ss_below_ref,
    // gate and analog controls
    input wire hs_gate,
    input wire ls_gate,
    input wire ss_discharge,
    input wire ref_sel_ss,
    input wire ls_sink_allow,
    input wire regulation_ok_output_o,
    input wire regulation_ok_output_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // flags cross a 2-flop sync, so a cause is held six clocks before its effect is due
    sequence s_stop_held;
        (undervoltage_lockout || !enable_above_thresh)[*6];
    endsequence
    sequence s_pg_bad_held;
        (undervoltage_lockout || !enable_above_thresh || !ss_above_1v4 || fb_out_window)[*6];
    endsequence
    sequence s_pg_good_held;
        (fb_in_window && !fb_out_window && ss_above_1v4 && !ss_discharge && !thermal_hot
         && !undervoltage_lockout && enable_above_thresh)[*6];
    endsequence
    a_gates_never_both: assert property (!(hs_gate && ls_gate))
        else $error("both gates on");
    a_idle_gates_off: assert property (ss_discharge[*3] |-> !hs_gate && !ls_gate)
        else $error("gate on while discharging");
    a_stop_gates_off: assert property (s_stop_held |-> !hs_gate && !ls_gate)
        else $error("switching during shutdown");
    a_ovp_hs_off: assert property (overvoltage_guard[*6] |-> !hs_gate)
        else $error("high side on during overvoltage");
    a_boot_hs_off: assert property (boot_uv[*6] |-> !hs_gate)
        else $error("high side on with bootstrap low");
    a_skip_hs_off: assert property (ls_source_limit[*6] |-> !hs_gate)
        else $error("high side on during sourcing limit");
    a_pg_release: assert property (s_pg_good_held |-> !regulation_ok_output_oe)
        else $error("power good not released");
    a_pg_pulldown: assert property (s_pg_bad_held |-> regulation_ok_output_oe)
        else $error("power good not pulled low");
    a_pg_drive_low: assert property (regulation_ok_output_o == 1'b0)
        else $error("power good pin driven high");
    a_ref_follows: assert property (ss_below_ref[*6] |-> ref_sel_ss)
        else $error("reference not taken from soft start");
    a_sink_blocked: assert property ((!ss_above_1v4)[*6] |-> !ls_sink_allow)
        else $error("sinking allowed below 1.4V");
endmodule // bps_seq_props
bind bps_sequencer bps_seq_props i_props (.aclk, .aresetn, .undervoltage_lockout,
    .enable_above_thresh, .thermal_hot, .fb_in_window, .fb_out_window, .overvoltage_guard,
    .boot_uv, .ls_source_limit, .ss_above_1v4, .ss_below_ref, .hs_gate, .ls_gate,
    .ss_discharge, .ref_sel_ss, .ls_sink_allow, .regulation_ok_output_o,
    .regulation_ok_output_oe);

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        aclk, aresetn, cycle_start, undervoltage_lockout, enable_above_thresh;
    logic        thermal_hot, thermal_cool, fb_in_window, fb_out_window, overvoltage_guard;
    logic        boot_uv, peak_current_trip, ls_source_limit, ls_sink_limit, overload;
    logic        ss_above_1v4, ss_at_ground, ss_below_ref, trip_en, irq, hs_any, hs_all, ls_all;
    logic        hs_gate, ls_gate, ss_discharge, ref_sel_ss, ls_sink_allow;
    logic        regulation_ok_output_o, regulation_ok_output_oe;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, wd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [5:0]  mask_exp;
    int          miscompares, cmp_count, cyc, n, seed;
    bps_sequencer i_dut (.aclk, .aresetn, .cycle_start, .undervoltage_lockout,
        .enable_above_thresh, .thermal_hot, .thermal_cool, .fb_in_window, .fb_out_window,
        .overvoltage_guard, .boot_uv, .peak_current_trip, .ls_source_limit, .ls_sink_limit,
        .overload, .ss_above_1v4, .ss_at_ground, .ss_below_ref, .hs_gate, .ls_gate,
        .ss_discharge, .ref_sel_ss, .ls_sink_allow, .regulation_ok_output_o,
        .regulation_ok_output_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    bps_analog_model i_model (.aclk, .hs_gate, .ss_discharge, .trip_en, .cycle_start,
        .peak_current_trip, .ss_above_1v4, .ss_at_ground, .ss_below_ref);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // two hiccups of 32768 clocks plus margin
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 90000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // only byte lane 0 carries the six mask bits
    function automatic logic [5:0] mask_next(input logic [5:0] m, input logic [31:0] d,
                                             input logic [3:0] s);
        return s[0] ? d[5:0] : m;
    endfunction
    // valids drop at the edge that sampled ready; a slow slave just stretches the loop
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_arvalid || !s_axi_rvalid) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic hs_mon(input int k);
        hs_any = 1'b0;
        hs_all = 1'b1;
        ls_all = 1'b1;
        repeat (k) begin
            @(posedge aclk);
            hs_any |= hs_gate;
            hs_all &= hs_gate;
            ls_all &= ls_gate;
        end
    endtask
    task automatic until_ss(input logic v);
        n = 0;
        while (ss_discharge !== v) begin
            @(posedge aclk);
            n++;
        end
    endtask
    initial begin
        seed = 5698;
        aresetn = 1'b0;
        enable_above_thresh = 1'b1;
        {undervoltage_lockout, thermal_hot, thermal_cool, fb_in_window, fb_out_window} = 5'h00;
        {overvoltage_guard, boot_uv, ls_source_limit, ls_sink_limit, overload, trip_en} = 6'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(8'h00);
        chk("ctrl reset", 32'h1, rd);
        axi_rd(8'h10);
        chk("hole read", 32'h2, {rd[29:0], rsp});
        axi_wr(8'h04, 32'hFFFF_FFFF, 4'hF);
        chk("status write resp", 32'h0, 32'(rsp));
        axi_rd(8'h0C);
        mask_exp = rd[5:0];
        chk("mask reset", 32'h0, rd);
        repeat (4) begin
            wd = $random(seed);
            n = $random(seed);
            axi_wr(8'h0C, wd, n[3:0]);
            mask_exp = mask_next(mask_exp, wd, n[3:0]);
            axi_rd(8'h0C);
            chk("mask readback", 32'(mask_exp), rd);
        end
        until_ss(1'b0);
        repeat (40) @(posedge aclk);
        hs_mon(20);
        chk("full duty", 32'h1, 32'(hs_all));
        boot_uv <= 1'b1;
        repeat (6) @(posedge aclk);
        hs_mon(10);
        chk("boot refresh", 32'h1, {hs_any, ls_gate});
        boot_uv <= 1'b0;
        trip_en <= 1'b1;
        repeat (6) @(posedge aclk);
        hs_mon(20);
        chk("peak pulses", 32'h2, {hs_any, hs_all});
        for (int i = 0; i < 2; i++) begin
            {overvoltage_guard, ls_source_limit} <= i ? 2'b10 : 2'b01;
            repeat (6) @(posedge aclk);
            hs_mon(20);
            chk("hs held off", 32'h0, 32'(hs_any));
            {overvoltage_guard, ls_source_limit} <= 2'b00;
            hs_mon(12);
            chk("hs resumed", 32'h1, 32'(hs_any));
        end
        for (int i = 0; i < 4; i++) begin
            {fb_in_window, fb_out_window} <= {i == 0, i == 2};
            repeat (8) @(posedge aclk);
            chk("power good", 32'(i >= 2), 32'(regulation_ok_output_oe));
        end
        // overvoltage parks the high side so the low side would stay on without the limit
        for (int i = 0; i < 2; i++) begin
            {overvoltage_guard, ls_sink_limit} <= {1'b1, i == 1};
            repeat (6) @(posedge aclk);
            hs_mon(20);
            chk("sink cut", 32'(i == 0), {hs_any, ls_all});
        end
        {overvoltage_guard, ls_sink_limit} <= 2'b00;
        axi_wr(8'h0C, 32'h0, 4'hF);
        axi_rd(8'h08);
        enable_above_thresh <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("stop state", 32'h3, {irq, hs_gate, ls_gate, ss_discharge, regulation_ok_output_oe});
        axi_wr(8'h0C, 32'h1, 4'h1);
        repeat (1) @(posedge aclk);
        chk("irq unmasked", 32'h1, 32'(irq));
        axi_rd(8'h08);
        repeat (1) @(posedge aclk);
        chk("irq event read", 32'h2, {rd[0], irq});
        enable_above_thresh <= 1'b1;
        until_ss(1'b0);
        chk("discharge first", 32'h1, 32'(n >= 8));
        repeat (40) @(posedge aclk);
        for (int i = 0; i < 2; i++) begin
            overload <= 1'b1;
            repeat (800) @(posedge aclk);
            overload <= 1'b0;
            repeat (10) @(posedge aclk);
        end
        chk("no hiccup", 32'h0, 32'(ss_discharge));
        overload <= 1'b1;
        until_ss(1'b1);
        chk("overload wait", 32'h1, 32'(n >= 1020 && n <= 1040));
        overload <= 1'b0;
        until_ss(1'b0);
        chk("overload hiccup", 32'h1, 32'(n >= 32768 && n <= 32800));
        thermal_hot <= 1'b1;
        repeat (10) @(posedge aclk);
        thermal_hot <= 1'b0;
        repeat (200) @(posedge aclk);
        chk("hot latched", 32'h1, 32'(ss_discharge));
        thermal_cool <= 1'b1;
        until_ss(1'b0);
        chk("thermal hiccup", 32'h1, 32'(n >= 32768 && n <= 32800));
        final_report();
    end
endmodule // tb

/* rtl/bps_defs.vh */
`ifndef BPS_DEFS_VH
`define BPS_DEFS_VH
// register byte offsets
`define BPS_OFF_CTRL     8'h00
`define BPS_OFF_STATUS   8'h04
`define BPS_OFF_IRQ      8'h08
`define BPS_OFF_MASK     8'h0C
// ctrl fields
`define BPS_CTRL_RUN     0
`define BPS_CTRL_RESET   32'h0000_0001
// status / irq bit positions
`define BPS_ST_SHUT      0
`define BPS_ST_OVLD      1
`define BPS_ST_THERM     2
`define BPS_ST_PGOOD     3
`define BPS_ST_SKIP      4
`define BPS_ST_SINK      5
`define BPS_IRQ_W        6
// timing counts in switching cycles
`define BPS_OVLD_WAIT    10'd512
`define BPS_HICCUP       15'd16384
// soft-start discharge hold in switching cycles
`define BPS_DISCH_MIN    4'd4
`endif

/* rtl/bps_sequencer.v */
// Behaviour
// - the error amp reference is the lower of the internal reference and the soft-start node.
// - undervoltage lockout, enable below 1.21V or thermal shutdown stops all switching.
// - after a shutdown clears, switching waits until the soft-start node is discharged.
// - power-good pull-down releases once feedback lies within 94% to 104% of reference.
// - power-good pull-down asserts when feedback is below 92% or above 106%.
// - power-good is also pulled low under lockout, thermal, enable low or soft-start below 1.4V.
// - full duty is allowed while the bootstrap is healthy, else high-side off and low-side on.
// - overvoltage holds high-side off; turn-on is allowed again only at the next cycle start.
// - peak current reaching the reference ends the high-side pulse and turns low-side on.
// - low-side sourcing over limit at cycle end skips the next high-side pulse.
// - after a skip, high-side resumes only at a cycle start with sourcing below limit.
// - sinking over limit turns low-side off at once, both off until the next cycle.
// - overload over 512 cycles shuts down and restarts after a 16384 cycle hiccup.
// - over-temperature stops switching; on cooling a 16384 cycle hiccup precedes restart.
// - during pre-biased start the low-side may not sink until soft-start exceeds 1.4V.
`timescale 1ns/1ps
`include "bps_defs.vh"
module bps_sequencer (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // switching-cycle oscillator tick, asynchronous pin
    input  wire        cycle_start,
    // comparator flags, asynchronous pins
    input  wire        undervoltage_lockout,
    input  wire        enable_above_thresh,
    input  wire        thermal_hot,
    input  wire        thermal_cool,
    input  wire        fb_in_window,
    input  wire        fb_out_window,
    input  wire        overvoltage_guard,
    input  wire        boot_uv,
    input  wire        peak_current_trip,
    input  wire        ls_source_limit,
    input  wire        ls_sink_limit,
    input  wire        overload,
    input  wire        ss_above_1v4,
    input  wire        ss_at_ground,
    input  wire        ss_below_ref,
    // gate and analog controls
    output reg         hs_gate,
    output reg         ls_gate,
    output reg         ss_discharge,
    output reg         ref_sel_ss,
    output reg         ls_sink_allow,
    output reg         regulation_ok_output_o,
    output reg         regulation_ok_output_oe,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // interrupt
    output wire        irq
);
    localparam N_IN = 16;
    localparam ST_OFF    = 3'd0;
    localparam ST_DISCH  = 3'd1;
    localparam ST_RUN    = 3'd2;
    localparam ST_HICCUP = 3'd3;
    localparam ST_THERM  = 3'd4;

    wire [N_IN-1:0] raw_in = {ss_below_ref, ss_at_ground, ss_above_1v4, overload,
                              ls_sink_limit, ls_source_limit, peak_current_trip, boot_uv,
                              overvoltage_guard, fb_out_window, fb_in_window, thermal_cool,
                              thermal_hot, enable_above_thresh, undervoltage_lockout,
                              cycle_start};
    reg  [N_IN-1:0] sync1_q;
    reg  [N_IN-1:0] sync2_q;
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_sync
            always @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    wire s_cyc   = sync2_q[0];
    wire s_undervoltage_lockout  = sync2_q[1];
    wire s_en    = sync2_q[2];
    wire s_hot   = sync2_q[3];
    wire s_cool  = sync2_q[4];
    wire s_fbin  = sync2_q[5];
    wire s_fbout = sync2_q[6];
    wire s_ovp   = sync2_q[7];
    wire s_bootu = sync2_q[8];
    wire s_peak  = sync2_q[9];
    wire s_src   = sync2_q[10];
    wire s_sink  = sync2_q[11];
    wire s_ovld  = sync2_q[12];
    wire s_ss14  = sync2_q[13];
    wire s_ssgnd = sync2_q[14];
    wire s_sslow = sync2_q[15];

    reg         cyc_d1_q;
    wire        tick = s_cyc & ~cyc_d1_q;
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [9:0]  ovld_cnt_q;
    reg  [14:0] hic_cnt_q;
    reg  [3:0]  dis_cnt_q;
    reg         therm_q;
    reg         skip_q;
    reg         sink_off_q;
    reg         ovp_hold_q;
    reg         hs_on_q;
    reg         pgood_q;
    reg  [31:0] ctrl_q;
    reg  [`BPS_IRQ_W-1:0] irq_q;
    reg  [`BPS_IRQ_W-1:0] mask_q;

    // a software stop acts like enable low
    wire shut_cause = s_undervoltage_lockout | ~s_en | therm_q | ~ctrl_q[`BPS_CTRL_RUN];
    wire ovld_trip  = (ovld_cnt_q == `BPS_OVLD_WAIT) & s_ovld & tick;

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF:    if (!shut_cause) state_d = ST_DISCH;
            ST_DISCH: begin
                if (shut_cause)
                    state_d = ST_OFF;
                else if (s_ssgnd && dis_cnt_q == `BPS_DISCH_MIN)
                    state_d = ST_RUN;
            end
            ST_RUN: begin
                if (shut_cause)
                    state_d = ST_OFF;
                else if (ovld_trip)
                    state_d = ST_HICCUP;
            end
            ST_HICCUP: begin
                if (shut_cause)
                    state_d = ST_OFF;
                else if (hic_cnt_q == `BPS_HICCUP)
                    state_d = ST_DISCH;
            end
            ST_THERM:  if (hic_cnt_q == `BPS_HICCUP) state_d = ST_OFF;
            default:   state_d = ST_OFF;
        endcase
        if (s_hot)
            state_d = ST_OFF;
        else if (therm_q && s_cool && state_q != ST_THERM)
            state_d = ST_THERM;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            cyc_d1_q   <= 1'b0;
            state_q    <= ST_OFF;
            ovld_cnt_q <= 10'h000;
            hic_cnt_q  <= 15'h0000;
            dis_cnt_q  <= 4'h0;
            therm_q    <= 1'b0;
        end else begin
            cyc_d1_q <= s_cyc;
            state_q  <= state_d;
            if (s_hot)
                therm_q <= 1'b1;
            else if (state_q == ST_THERM && state_d == ST_OFF)
                therm_q <= 1'b0;
            if (state_q != ST_RUN || !s_ovld)
                ovld_cnt_q <= 10'h000;
            else if (tick && ovld_cnt_q != `BPS_OVLD_WAIT)
                ovld_cnt_q <= ovld_cnt_q + 10'h001;
            if (state_d != state_q)
                hic_cnt_q <= 15'h0000;
            else if (tick && (state_q == ST_HICCUP || state_q == ST_THERM)
                     && hic_cnt_q != `BPS_HICCUP)
                hic_cnt_q <= hic_cnt_q + 15'h0001;
            if (state_q != ST_DISCH || !s_ssgnd)
                dis_cnt_q <= 4'h0;
            else if (tick && dis_cnt_q != `BPS_DISCH_MIN)
                dis_cnt_q <= dis_cnt_q + 4'h1;
        end
    end

    // gate sequencing within each switching cycle
    wire run = (state_q == ST_RUN);
    always @(posedge aclk) begin
        if (!aresetn) begin
            hs_on_q    <= 1'b0;
            skip_q     <= 1'b0;
            sink_off_q <= 1'b0;
            ovp_hold_q <= 1'b0;
        end else if (!run) begin
            hs_on_q    <= 1'b0;
            skip_q     <= 1'b0;
            sink_off_q <= 1'b0;
            ovp_hold_q <= 1'b0;
        end else begin
            if (s_ovp)
                ovp_hold_q <= 1'b1;
            else if (tick)
                ovp_hold_q <= 1'b0;
            if (tick) begin
                sink_off_q <= 1'b0;
                skip_q     <= s_src;
                hs_on_q    <= ~s_src & ~s_ovp & ~s_bootu;
            end else begin
                // the hold keeps the high side off for the rest of a cycle that saw overvoltage
                if (s_peak || s_ovp || ovp_hold_q || s_bootu)
                    hs_on_q <= 1'b0;
                if (s_sink && !hs_on_q)
                    sink_off_q <= 1'b1;
            end
        end
    end

    // outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            hs_gate       <= 1'b0;
            ls_gate       <= 1'b0;
            ss_discharge  <= 1'b1;
            ref_sel_ss    <= 1'b1;
            ls_sink_allow <= 1'b0;
            pgood_q       <= 1'b0;
            regulation_ok_output_o  <= 1'b0;
            regulation_ok_output_oe <= 1'b1;
        end else begin
            hs_gate <= run & hs_on_q & ~s_ovp & ~s_peak;
            ls_gate <= run & ~hs_on_q & ~sink_off_q & ~(s_sink & ~s_ss14);
            ls_sink_allow <= run & s_ss14;
            ss_discharge  <= (state_q != ST_RUN);
            ref_sel_ss    <= s_sslow;
            if (shut_cause || !s_ss14 || state_q != ST_RUN)
                pgood_q <= 1'b0;
            else if (s_fbout)
                pgood_q <= 1'b0;
            else if (s_fbin)
                pgood_q <= 1'b1;
            regulation_ok_output_o  <= 1'b0;
            regulation_ok_output_oe <= ~pgood_q;
        end
    end

    // axi4-lite register slave
    reg aw_q;
    reg w_q;
    reg [7:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire [`BPS_IRQ_W-1:0] ev = {sink_off_q & run, skip_q & run, pgood_q,
                                state_q == ST_THERM, state_q == ST_HICCUP,
                                state_q == ST_OFF};
    reg  [`BPS_IRQ_W-1:0] ev_d1_q;
    wire [`BPS_IRQ_W-1:0] ev_rise = ev & ~ev_d1_q;
    wire rd_irq = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `BPS_OFF_IRQ);
    wire do_wr  = aw_q & w_q & ~s_axi_bvalid;
    assign irq = |(irq_q & mask_q);

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
        end
    endfunction
    wire [31:0] mask_wr = merge({26'h0, mask_q}, wdata_q, wstrb_q);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0000_0000;
            ctrl_q <= `BPS_CTRL_RESET;
            mask_q <= {`BPS_IRQ_W{1'b0}};
            irq_q <= {`BPS_IRQ_W{1'b0}};
            ev_d1_q <= {`BPS_IRQ_W{1'b0}};
        end else begin
            ev_d1_q <= ev;
            // a new event wins over the clear by read
            irq_q <= (rd_irq ? {`BPS_IRQ_W{1'b0}} : irq_q) | ev_rise;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                case (awaddr_q)
                    `BPS_OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0001;
                    `BPS_OFF_MASK: mask_q <= mask_wr[`BPS_IRQ_W-1:0];
                    `BPS_OFF_STATUS, `BPS_OFF_IRQ: s_axi_bresp <= 2'b00;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `BPS_OFF_CTRL:   s_axi_rdata <= ctrl_q;
                    `BPS_OFF_STATUS: s_axi_rdata <= {26'h0, ev};
                    `BPS_OFF_IRQ:    s_axi_rdata <= {26'h0, irq_q};
                    `BPS_OFF_MASK:   s_axi_rdata <= {26'h0, mask_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // bps_sequencer
